// [include/fpkm_defines.vh]
// front panel key menu: constants shared by the key menu design files
// assumes a single 50 MHz clock and plain Verilog-2005 tools
`ifndef FPKM_DEFINES_VH
`define FPKM_DEFINES_VH

// ******************************************
// timing
// ******************************************
`define FPKM_CLK_HZ        50000000
`define FPKM_DEBOUNCE_US   10000
`define FPKM_HOLD_MS       1000
`define FPKM_SEC_RPT_MS    200
`define FPKM_LINE_RPT_MS   100
`define FPKM_FLASH_MS      2000
`define FPKM_DEBOUNCE_CYC  (`FPKM_CLK_HZ / 1000000 * `FPKM_DEBOUNCE_US)
`define FPKM_HOLD_CYC      (`FPKM_CLK_HZ / 1000 * `FPKM_HOLD_MS)
`define FPKM_SEC_RPT_CYC   (`FPKM_CLK_HZ / 1000 * `FPKM_SEC_RPT_MS)
`define FPKM_LINE_RPT_CYC  (`FPKM_CLK_HZ / 1000 * `FPKM_LINE_RPT_MS)
`define FPKM_FLASH_CYC     (`FPKM_CLK_HZ / 1000 * `FPKM_FLASH_MS)

// ******************************************
// key indices
// ******************************************
`define FPKM_NKEYS         13
`define FPKM_K_SETVIEW     0
`define FPKM_K_ACTVIEW     1
`define FPKM_K_COMMIT      2
`define FPKM_K_STOP        3
`define FPKM_K_RESET       4
`define FPKM_K_STARTA      5
`define FPKM_K_STARTB      6
`define FPKM_K_SECUP       7
`define FPKM_K_SECDN       8
`define FPKM_K_LINEL       9
`define FPKM_K_LINER       10
`define FPKM_K_VALUP       11
`define FPKM_K_VALDN       12

// ******************************************
// menu geometry and trip kinds
// ******************************************
`define FPKM_SP_PAGES      3'h6
`define FPKM_ACT_PAGES     3'h4
`define FPKM_TRIP_W        4
`define FPKM_GUARD_RST     4'h7

`endif

// [rtl/fpkm_key_filter.v]
// front panel key menu: one key debouncer with press and hold-repeat pulses
// assumes the key level is already synchronised to clk_in
`timescale 1ns/1ns
module fpkm_key_filter #(
  parameter DEB_CYC = 500000,
  parameter HOLD_CYC = 50000000,
  parameter RPT_CYC = 10000000
) (
  // clock and reset
  input  wire clk_in,
  input  wire sys_rst_in,
  // key level and actions
  input  wire key_in,
  output reg  press_out,
  output reg  repeat_out
);

  reg  [31:0] deb_cnt_q;
  reg  [31:0] hold_cnt_q;
  reg         state_q;

  // debounce: level must hold steady for the whole window before it counts
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      deb_cnt_q  <= 32'h0;
      hold_cnt_q <= 32'h0;
      state_q    <= 1'b0;
      press_out  <= 1'b0;
      repeat_out <= 1'b0;
    end else begin
      press_out  <= 1'b0;
      repeat_out <= 1'b0;
      if (key_in == state_q) begin
        deb_cnt_q <= 32'h0;
      end else if (deb_cnt_q >= DEB_CYC - 1) begin
        deb_cnt_q <= 32'h0;
        state_q   <= key_in;
        press_out <= key_in;
      end else begin
        deb_cnt_q <= deb_cnt_q + 32'h1;
      end
      // hold timer: first repeat after the hold time plus one repeat period, then every repeat period
      if (!state_q) begin
        hold_cnt_q <= 32'h0;
      end else if (hold_cnt_q >= HOLD_CYC + RPT_CYC - 1) begin
        hold_cnt_q <= HOLD_CYC;
        repeat_out <= 1'b1;
      end else begin
        hold_cnt_q <= hold_cnt_q + 32'h1;
      end
    end
  end

endmodule // fpkm_key_filter

// [rtl/fpkm_key_menu.v]
// front panel key menu: keypad command interpreter for a motor relay
// assumes raw key levels from the keypad, setpoint store and trip logic outside
`timescale 1ns/1ns
`include "fpkm_defines.vh"
module fpkm_key_menu #(
  parameter VAL_W      = 16,
  parameter SEC_W      = 4,
  parameter LINE_W     = 5,
  parameter DEB_CYC    = `FPKM_DEBOUNCE_CYC,
  parameter HOLD_CYC   = `FPKM_HOLD_CYC,
  parameter SRPT_CYC   = `FPKM_SEC_RPT_CYC,
  parameter LRPT_CYC   = `FPKM_LINE_RPT_CYC,
  parameter FLASH_CYC  = `FPKM_FLASH_CYC
) (
  // clock and reset
  input  wire                      clk_in,
  input  wire                      sys_rst_in,
  // raw keypad levels, one bit per key, high while pressed
  input  wire [`FPKM_NKEYS-1:0]    keys_in,
  // menu geometry from the message tables
  input  wire [SEC_W-1:0]          last_sec_in,
  input  wire [LINE_W-1:0]         last_line_in,
  input  wire                      is_setpoint_in,
  input  wire [VAL_W-1:0]          val_min_in,
  input  wire [VAL_W-1:0]          val_max_in,
  // setpoint store
  input  wire [VAL_W-1:0]          stored_val_in,
  output reg  [VAL_W-1:0]          edit_val_out,
  output reg                       store_wr_out,
  output reg  [VAL_W-1:0]          store_data_out,
  output reg                       default_sel_out,
  // display position and messages
  output reg                       mode_sp_out,
  output reg  [2:0]                page_out,
  output reg  [SEC_W-1:0]          sec_out,
  output reg  [LINE_W-1:0]         line_out,
  output reg                       msg_stored_out,
  output reg                       msg_no_reset_out,
  // remote start sources
  input  wire                      rear_start_a_in,
  input  wire                      rear_start_b_in,
  input  wire                      ser_start_a_in,
  input  wire                      ser_start_b_in,
  // trip logic
  input  wire [`FPKM_TRIP_W-1:0]   trip_kind_in,
  input  wire                      trip_cause_in,
  input  wire                      lockout_assign_in,
  input  wire                      lockout_rst_in,
  output reg                       tripped_out,
  input  wire                      trip_set_in,
  // contactor relays and start sequencer
  output reg                       relay_a_out,
  output reg                       relay_b_out,
  output reg                       start_a_out,
  output reg                       start_b_out
);

  // ******************************************
  // input synchronisers
  // ******************************************
  localparam NS = `FPKM_NKEYS + 4;
  wire [NS-1:0] raw_w = {rear_start_a_in, rear_start_b_in, lockout_rst_in,
                         trip_cause_in, keys_in};
  reg  [NS-1:0] sync1_q;
  reg  [NS-1:0] sync2_q;
  reg           rsa_q;
  reg           rsb_q;
  reg           lrst_q;

  // two flops on the keys, rear starts, lockout reset and trip cause; edge detect only looks at the second stage
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1_q <= {NS{1'b0}};
      sync2_q <= {NS{1'b0}};
      rsa_q   <= 1'b0;
      rsb_q   <= 1'b0;
      lrst_q  <= 1'b0;
    end else begin
      sync1_q <= raw_w;
      sync2_q <= sync1_q;
      rsa_q   <= sync2_q[NS-1];
      rsb_q   <= sync2_q[NS-2];
      lrst_q  <= sync2_q[NS-3];
    end
  end

  wire       cause_w   = sync2_q[NS-4];
  wire       rear_a_w  = sync2_q[NS-1] & ~rsa_q;
  wire       rear_b_w  = sync2_q[NS-2] & ~rsb_q;
  wire       lock_w    = sync2_q[NS-3] & ~lrst_q;

  // ******************************************
  // key filters
  // ******************************************
  wire [`FPKM_NKEYS-1:0] press_w;
  wire [`FPKM_NKEYS-1:0] rpt_w;

  // navigation keys repeat; sections slower than lines
  genvar gi;
  generate
    for (gi = 0; gi < `FPKM_NKEYS; gi = gi + 1) begin : g_key
      localparam RP = (gi == `FPKM_K_LINEL || gi == `FPKM_K_LINER) ? LRPT_CYC : SRPT_CYC;
      wire rpt_raw;
      fpkm_key_filter #(
        .DEB_CYC  (DEB_CYC),
        .HOLD_CYC (HOLD_CYC),
        .RPT_CYC  (RP)
      ) u_filt (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .key_in     (sync2_q[gi]),
        .press_out  (press_w[gi]),
        .repeat_out (rpt_raw)
      );
      assign rpt_w[gi] = (gi >= `FPKM_K_SECUP && gi <= `FPKM_K_LINER) ? rpt_raw : 1'b0;
    end
  endgenerate

  wire [`FPKM_NKEYS-1:0] act_w = press_w | rpt_w;

  // ******************************************
  // menu state machine
  // ******************************************
  localparam ST_ACT = 2'b01;
  localparam ST_SP  = 2'b10;
  reg [1:0] st_q;
  reg       edited_q;
  reg [31:0] flash_cnt_q;

  // guarded trips may only be cleared from the lockout input when assigned
  wire guarded_w  = lockout_assign_in && (trip_kind_in <= `FPKM_GUARD_RST);
  wire front_rst_w = press_w[`FPKM_K_RESET] & ~guarded_w;
  wire rst_req_w  = front_rst_w | (lock_w & guarded_w);

  // navigation, editing, commit and message flash
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q            <= ST_ACT;
      page_out        <= 3'h0;
      sec_out         <= {SEC_W{1'b0}};
      line_out        <= {LINE_W{1'b0}};
      mode_sp_out     <= 1'b0;
      edit_val_out    <= {VAL_W{1'b0}};
      edited_q        <= 1'b0;
      store_wr_out    <= 1'b0;
      store_data_out  <= {VAL_W{1'b0}};
      default_sel_out <= 1'b0;
      msg_stored_out  <= 1'b0;
      flash_cnt_q     <= 32'h0;
    end else begin
      store_wr_out    <= 1'b0;
      default_sel_out <= 1'b0;
      // shown value follows the stored one until the user edits it
      if (!edited_q) begin
        edit_val_out <= stored_val_in;
      end
      if (flash_cnt_q != 32'h0) begin
        flash_cnt_q <= flash_cnt_q - 32'h1;
      end else begin
        msg_stored_out <= 1'b0;
      end
      case (st_q)
        ST_ACT: begin
          mode_sp_out <= 1'b0;
          if (press_w[`FPKM_K_SETVIEW]) begin
            st_q     <= ST_SP;
            page_out <= 3'h0;
            sec_out  <= {SEC_W{1'b0}};
            line_out <= {LINE_W{1'b0}};
          end else if (press_w[`FPKM_K_ACTVIEW]) begin
            page_out <= (page_out == `FPKM_ACT_PAGES - 3'h1) ? 3'h0 : page_out + 3'h1;
            sec_out  <= {SEC_W{1'b0}};
            line_out <= {LINE_W{1'b0}};
          end else if (press_w[`FPKM_K_COMMIT]) begin
            default_sel_out <= 1'b1;
          end
        end
        ST_SP: begin
          mode_sp_out <= 1'b1;
          if (press_w[`FPKM_K_SETVIEW]) begin
            page_out <= (page_out == `FPKM_SP_PAGES - 3'h1) ? 3'h0 : page_out + 3'h1;
            sec_out  <= {SEC_W{1'b0}};
            line_out <= {LINE_W{1'b0}};
            edited_q <= 1'b0;
          end else if (press_w[`FPKM_K_ACTVIEW]) begin
            st_q     <= ST_ACT;
            page_out <= 3'h0;
            sec_out  <= {SEC_W{1'b0}};
            line_out <= {LINE_W{1'b0}};
            edited_q <= 1'b0;
          end else if (press_w[`FPKM_K_COMMIT] && is_setpoint_in) begin
            store_wr_out   <= 1'b1;
            store_data_out <= edit_val_out;
            edited_q       <= 1'b0;
            msg_stored_out <= 1'b1;
            flash_cnt_q    <= FLASH_CYC - 1; // flag stands exactly FLASH_CYC cycles
          end else if (act_w[`FPKM_K_VALUP] && is_setpoint_in) begin
            edited_q <= 1'b1;
            if (edit_val_out < val_max_in) begin
              edit_val_out <= edit_val_out + {{(VAL_W-1){1'b0}}, 1'b1};
            end
          end else if (act_w[`FPKM_K_VALDN] && is_setpoint_in) begin
            edited_q <= 1'b1;
            if (edit_val_out > val_min_in) begin
              edit_val_out <= edit_val_out - {{(VAL_W-1){1'b0}}, 1'b1};
            end
          end
        end
        default: begin
          st_q <= ST_ACT;
        end
      endcase
      // section and line moves are common to both views
      if (!press_w[`FPKM_K_SETVIEW] && !press_w[`FPKM_K_ACTVIEW]) begin
        if (act_w[`FPKM_K_SECDN] && sec_out != last_sec_in) begin
          sec_out  <= sec_out + {{(SEC_W-1){1'b0}}, 1'b1};
          line_out <= {LINE_W{1'b0}};
          edited_q <= 1'b0;
        end else if (act_w[`FPKM_K_SECUP] && sec_out != {SEC_W{1'b0}}) begin
          sec_out  <= sec_out - {{(SEC_W-1){1'b0}}, 1'b1};
          line_out <= {LINE_W{1'b0}};
          edited_q <= 1'b0;
        end else if (act_w[`FPKM_K_LINER] && line_out != last_line_in) begin
          line_out <= line_out + {{(LINE_W-1){1'b0}}, 1'b1};
          edited_q <= 1'b0;
        end else if (act_w[`FPKM_K_LINEL] && line_out != {LINE_W{1'b0}}) begin
          line_out <= line_out - {{(LINE_W-1){1'b0}}, 1'b1};
          edited_q <= 1'b0;
        end
      end
    end
  end

  // ******************************************
  // trip, stop and start commands
  // ******************************************
  // stop wins over any start in the same cycle, and a trip blocks starts
  always @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tripped_out      <= 1'b0;
      msg_no_reset_out <= 1'b0;
      relay_a_out      <= 1'b0;
      relay_b_out      <= 1'b0;
      start_a_out      <= 1'b0;
      start_b_out      <= 1'b0;
    end else begin
      start_a_out <= 1'b0;
      start_b_out <= 1'b0;
      if (press_w[`FPKM_K_RESET] || lock_w) begin
        msg_no_reset_out <= 1'b0;
      end
      // a new trip wins over a reset in the same cycle
      if (trip_set_in) begin
        tripped_out <= 1'b1;
      end else if (rst_req_w && tripped_out) begin
        if (cause_w) begin
          msg_no_reset_out <= 1'b1;
        end else begin
          tripped_out <= 1'b0;
        end
      end
      if (press_w[`FPKM_K_STOP] || trip_set_in) begin
        relay_a_out <= 1'b0;
        relay_b_out <= 1'b0;
      end else if (!tripped_out) begin
        if (press_w[`FPKM_K_STARTA] || rear_a_w || ser_start_a_in) begin
          start_a_out <= 1'b1;
          relay_a_out <= 1'b1;
          relay_b_out <= 1'b0;
        end else if (press_w[`FPKM_K_STARTB] || rear_b_w || ser_start_b_in) begin
          start_b_out <= 1'b1;
          relay_b_out <= 1'b1;
          relay_a_out <= 1'b0;
        end
      end
    end
  end

endmodule // fpkm_key_menu

// [testbench/fpkm_key_menu_chk.sv]
// key menu checker: timing relations between the key menu outputs
// assumes one clock domain and a bind onto fpkm_key_menu
`timescale 1ns/1ns
module fpkm_key_menu_chk #(
  parameter VAL_W  = 16,
  parameter SEC_W  = 4,
  parameter LINE_W = 5
) (
  // clock, reset and geometry
  input wire              clk_in,
  input wire              sys_rst_in,
  input wire              is_setpoint_in,
  // store and position
  input wire [VAL_W-1:0]  edit_val_out,
  input wire [VAL_W-1:0]  store_data_out,
  input wire              store_wr_out,
  input wire              default_sel_out,
  input wire              mode_sp_out,
  input wire [2:0]        page_out,
  input wire [SEC_W-1:0]  sec_out,
  input wire [LINE_W-1:0] line_out,
  // messages, trip and relays
  input wire              msg_stored_out,
  input wire              msg_no_reset_out,
  input wire              tripped_out,
  input wire              relay_a_out,
  input wire              relay_b_out,
  input wire              start_a_out,
  input wire              start_b_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  store_data_a: assert property (store_wr_out |-> store_data_out == edit_val_out)
    else $error("stored value differs from shown value");
  store_msg_a: assert property (store_wr_out |-> msg_stored_out)
    else $error("no confirmation with commit");
  commit_view_a: assert property (store_wr_out |-> mode_sp_out && is_setpoint_in)
    else $error("commit outside setpoint line");
  default_view_a: assert property (default_sel_out |-> !mode_sp_out)
    else $error("default pick outside measured view");
  store_once_a: assert property (store_wr_out |=> !store_wr_out)
    else $error("one commit gave two writes");
  no_reset_a: assert property ($rose(msg_no_reset_out) |-> tripped_out)
    else $error("refusal shown while not tripped");
  start_a_relay_a: assert property (start_a_out |-> ##[0:1] relay_a_out && !relay_b_out)
    else $error("start a left relays wrong");
  start_b_relay_a: assert property (start_b_out |-> ##[0:1] relay_b_out)
    else $error("start b left relay b off");
  trip_start_a: assert property ($past(tripped_out) && tripped_out |-> !start_a_out && !start_b_out)
    else $error("start while tripped");
  sec_step_a: assert property ($changed(sec_out) && $stable(page_out) && $stable(mode_sp_out)
    |-> sec_out == $past(sec_out) + 1'b1 || sec_out == $past(sec_out) - 1'b1)
    else $error("section moved by more than one");
  line_step_a: assert property ($changed(line_out) && $stable(sec_out) && $stable(page_out)
    |-> line_out == $past(line_out) + 1'b1 || line_out == $past(line_out) - 1'b1)
    else $error("line moved by more than one");
  value_view_a: assert property ($changed(edit_val_out) && $stable(mode_sp_out) && $stable(page_out)
    && $stable(sec_out) && $stable(line_out) |-> mode_sp_out)
    else $error("value changed in measured view");
endmodule // fpkm_key_menu_chk
bind fpkm_key_menu fpkm_key_menu_chk #(.VAL_W(VAL_W), .SEC_W(SEC_W), .LINE_W(LINE_W)) i_chk (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .is_setpoint_in(is_setpoint_in),
  .edit_val_out(edit_val_out), .store_data_out(store_data_out), .store_wr_out(store_wr_out),
  .default_sel_out(default_sel_out), .mode_sp_out(mode_sp_out), .page_out(page_out),
  .sec_out(sec_out), .line_out(line_out), .msg_stored_out(msg_stored_out),
  .msg_no_reset_out(msg_no_reset_out), .tripped_out(tripped_out), .relay_a_out(relay_a_out),
  .relay_b_out(relay_b_out), .start_a_out(start_a_out), .start_b_out(start_b_out));

// [testbench/fpkm_operator.sv]
// operator model: presses front panel keys with contact bounce
// assumes the bench calls press from one process at a time
`timescale 1ns/1ns
module fpkm_operator (
  // clock and keypad
  input  wire         clk_in,
  output logic [12:0] keys_out
);
  initial keys_out = 13'h0000;
  // bounce on make and break, so a weak debounce shows double actions
  task automatic press(input int k, input int hold);
    int i;
    for (i = 0; i < 3; i++) begin
      @(posedge clk_in);
      #1 keys_out[k] = ~keys_out[k];
    end
    repeat (hold) @(posedge clk_in);
    for (i = 0; i < 3; i++) begin
      #1 keys_out[k] = ~keys_out[k];
      @(posedge clk_in);
    end
  endtask
endmodule // fpkm_operator

// [testbench/fpkm_key_menu_tb.sv]
// key menu bench: scenario tasks drive keys, starts and trips, then judge outputs
// assumes short debounce and hold counts set by parameter
`timescale 1ns/1ns
`include "fpkm_defines.vh"
`define FPKM_CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module fpkm_key_menu_tb;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  wire  [12:0] keys_in;
  logic [3:0]  last_sec = 4'h2;
  logic [4:0]  last_line = 5'h1;
  logic [15:0] stored = 16'h0000;
  logic [3:0]  kind = 4'h0;
  logic [15:0] vmin = 16'h0000;
  logic [15:0] vmax = 16'hFFFF;
  logic        is_sp, rear_a, rear_b, ser_a, ser_b, cause, lk_as, lk_rst, trip_set;
  wire  [15:0] edit_val, store_data;
  wire  [3:0]  sec;
  wire  [4:0]  line;
  wire  [2:0]  page;
  wire         wr, dsel, mode, msg, nores, tripped, ra, rb, sa, sb;
  int          failures = 0, n_checks = 0, n_wr = 0, n_def = 0, n_sa = 0, n_sb = 0, n_msg = 0;
  always #10 clk_in = ~clk_in;
  fpkm_operator i_fpkm_operator (.clk_in(clk_in), .keys_out(keys_in));
  fpkm_key_menu #(.DEB_CYC(4), .HOLD_CYC(20), .SRPT_CYC(8), .LRPT_CYC(4), .FLASH_CYC(10))
  i_fpkm_key_menu (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .keys_in(keys_in),
    .last_sec_in(last_sec), .last_line_in(last_line), .is_setpoint_in(is_sp),
    .val_min_in(vmin), .val_max_in(vmax), .stored_val_in(stored),
    .edit_val_out(edit_val), .store_wr_out(wr), .store_data_out(store_data),
    .default_sel_out(dsel), .mode_sp_out(mode), .page_out(page), .sec_out(sec),
    .line_out(line), .msg_stored_out(msg), .msg_no_reset_out(nores),
    .rear_start_a_in(rear_a), .rear_start_b_in(rear_b), .ser_start_a_in(ser_a),
    .ser_start_b_in(ser_b), .trip_kind_in(kind), .trip_cause_in(cause),
    .lockout_assign_in(lk_as), .lockout_rst_in(lk_rst), .tripped_out(tripped),
    .trip_set_in(trip_set), .relay_a_out(ra), .relay_b_out(rb), .start_a_out(sa),
    .start_b_out(sb));
  // pulses last one cycle and the stored flag is timed by count, so they are tallied here rather than polled
  always @(posedge clk_in) begin
    if (wr === 1'b1) n_wr++;
    if (dsel === 1'b1) n_def++;
    if (sa === 1'b1) n_sa++;
    if (sb === 1'b1) n_sb++;
    if (msg === 1'b1) n_msg++;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // shared drivers
  // ****************************************
  task automatic key(input int k, input int h = 10);
    i_fpkm_operator.press(k, h);
    repeat (12) @(posedge clk_in);
    #1;
  endtask
  task automatic pulse_trip;
    #1 trip_set = 1'b1;
    @(posedge clk_in);
    #1 trip_set = 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
  endtask
  // one-cycle serial start request, b selects start b
  task automatic pulse_ser(input bit b);
    #1;
    if (b) ser_b = 1'b1;
    else ser_a = 1'b1;
    @(posedge clk_in);
    #1 {ser_a, ser_b} = 2'b00;
    repeat (4) @(posedge clk_in);
    #1;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_nav;
    int i;
    key(`FPKM_K_SETVIEW);
    `FPKM_CHK("first page", 4'h8, {mode, page})
    key(`FPKM_K_SETVIEW);
    `FPKM_CHK("next page", 3'h1, page)
    key(`FPKM_K_SECUP);
    `FPKM_CHK("up at heading", 4'h0, sec)
    for (i = 0; i < 3; i++) key(`FPKM_K_SECDN);
    `FPKM_CHK("down at end", 4'h2, sec)
    key(`FPKM_K_SECUP);
    `FPKM_CHK("section up", 4'h1, sec)
    key(`FPKM_K_LINEL);
    `FPKM_CHK("left at heading", 5'h0, line)
    for (i = 0; i < 2; i++) key(`FPKM_K_LINER);
    `FPKM_CHK("right at end", 5'h1, line)
  endtask
  task automatic t_hold;
    last_sec = 4'h5;
    last_line = 5'h3;
    key(`FPKM_K_SECDN, 70);
    `FPKM_CHK("section repeat", 4'h5, sec)
    key(`FPKM_K_LINER, 60);
    `FPKM_CHK("line repeat", 5'h3, line)
  endtask
  task automatic t_edit;
    int w;
    is_sp = 1'b1;
    stored = 16'h0010;
    key(`FPKM_K_LINEL);
    `FPKM_CHK("loaded", 16'h0010, edit_val)
    w = n_wr;
    key(`FPKM_K_VALUP);
    key(`FPKM_K_VALUP);
    `FPKM_CHK("value up", 16'h0012, edit_val)
    `FPKM_CHK("no write", w, n_wr)
    w = n_msg;
    key(`FPKM_K_COMMIT);
    `FPKM_CHK("write", 16'h0012, store_data)
    `FPKM_CHK("flash length", w + 10, n_msg)
    stored = 16'h0012;
    key(`FPKM_K_VALDN);
    `FPKM_CHK("value down", 16'h0011, edit_val)
    key(`FPKM_K_LINER);
    key(`FPKM_K_LINEL);
    `FPKM_CHK("reverted", 16'h0012, edit_val)
    vmax = 16'h0012;
    key(`FPKM_K_VALUP);
    `FPKM_CHK("upper limit", 16'h0012, edit_val)
    vmin = 16'h0012;
    key(`FPKM_K_VALDN);
    `FPKM_CHK("lower limit", 16'h0012, edit_val)
    is_sp = 1'b0;
    w = n_wr;
    key(`FPKM_K_COMMIT);
    `FPKM_CHK("commit on label", w, n_wr)
  endtask
  task automatic t_actual;
    logic [15:0] e;
    int d;
    key(`FPKM_K_ACTVIEW);
    `FPKM_CHK("measured view", 1'b0, mode)
    is_sp = 1'b1;
    e = edit_val;
    d = n_def;
    key(`FPKM_K_VALUP);
    `FPKM_CHK("value ignored", e, edit_val)
    key(`FPKM_K_COMMIT);
    `FPKM_CHK("default pick", d + 1, n_def)
    is_sp = 1'b0;
  endtask
  task automatic t_trip;
    int i;
    key(`FPKM_K_STARTA);
    `FPKM_CHK("front start a", 1'b1, ra)
    pulse_trip;
    #1 cause = 1'b1;
    key(`FPKM_K_RESET);
    `FPKM_CHK("refused", 2'h3, {tripped, nores})
    cause = 1'b0;
    key(`FPKM_K_RESET);
    `FPKM_CHK("cleared", 2'h0, {tripped, nores})
    lk_as = 1'b1;
    kind = 4'h7;
    pulse_trip;
    key(`FPKM_K_RESET);
    `FPKM_CHK("guarded", 1'b1, tripped)
    #1 lk_rst = 1'b1;
    for (i = 0; i < 10 && tripped !== 1'b0; i++) @(posedge clk_in);
    #1 lk_rst = 1'b0;
    `FPKM_CHK("lockout clear", 1'b0, tripped)
    kind = 4'h8;
    pulse_trip;
    key(`FPKM_K_RESET);
    `FPKM_CHK("not guardable", 1'b0, tripped)
    lk_as = 1'b0;
  endtask
  task automatic t_start;
    int a, b;
    a = n_sa;
    b = n_sb;
    #1 rear_b = 1'b1;
    repeat (8) @(posedge clk_in);
    `FPKM_CHK("rear start b", {b + 1, 1'b1}, {n_sb, rb})
    #1 rear_b = 1'b0;
    key(`FPKM_K_STOP);
    `FPKM_CHK("stop", 2'h0, {ra, rb})
    pulse_ser(1'b0);
    `FPKM_CHK("serial start a", {a + 1, 1'b1}, {n_sa, ra})
    key(`FPKM_K_STARTB);
    `FPKM_CHK("front start b", b + 2, n_sb)
    key(`FPKM_K_STOP);
    pulse_trip;
    pulse_ser(1'b0);
    `FPKM_CHK("start while tripped", a + 1, n_sa)
    key(`FPKM_K_RESET);
    #1 rear_a = 1'b1;
    repeat (8) @(posedge clk_in);
    `FPKM_CHK("rear start a", {a + 2, 1'b1}, {n_sa, ra})
    #1 rear_a = 1'b0;
    pulse_ser(1'b1);
    `FPKM_CHK("serial start b", {b + 3, 1'b1}, {n_sb, rb})
  endtask
  // reset, then each scenario in turn
  initial begin
    {is_sp, rear_a, rear_b, ser_a, ser_b, cause, lk_as, lk_rst, trip_set} = 9'h000;
    repeat (16) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    repeat (4) @(posedge clk_in);
    `FPKM_CHK("after reset", 4'h0, {mode, tripped, ra, rb})
    t_nav;
    t_hold;
    t_edit;
    t_actual;
    t_trip;
    t_start;
    close_out;
  end
  // watchdog well above the roughly 1150 cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clk_in);
    failures++;
    close_out;
  end
endmodule // fpkm_key_menu_tb
